// ==== inc/asc_cfg.svh ====
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ****************************************
// register offsets in the internal i/o space, channel 1 at offset + 1
// ****************************************
`define ASC_OFF_CTLA 8'h00
`define ASC_OFF_CTLB 8'h02
`define ASC_OFF_STAT 8'h04
`define ASC_OFF_TDR 8'h06
`define ASC_OFF_RDR 8'h08

// ****************************************
// field positions
// ****************************************
`define ASC_A_WAKE 7
`define ASC_A_RXON 6
`define ASC_A_TXON 5
`define ASC_A_PIN 4
`define ASC_A_EFR 3
`define ASC_A_LEN8 2
`define ASC_A_PAR 1
`define ASC_A_STOP2 0
`define ASC_B_TXMPB 7
`define ASC_B_MP 6
`define ASC_B_PS 5
`define ASC_B_ODD 4
`define ASC_S_RIE 3
`define ASC_S_TIE 0

// ****************************************
// reset values
// ****************************************
`define ASC_CTLA0_RST 8'h10
`define ASC_CTLA1_RST 8'h00
`define ASC_CTLB_RST 8'h07

// ****************************************
// timing: fixed bit time, prescaler not modelled
// ****************************************
`define ASC_CLK_NS 8
`define ASC_BIT_NS 8680
`define ASC_BIT_CYC (`ASC_BIT_NS / `ASC_CLK_NS)
`define ASC_DIV_W 12

`endif

// ==== inc/asc_pkg.sv ====
package asc_pkg;
  typedef enum logic [0:0] {
    asc_tx_idle = 1'b0,
    asc_tx_shift = 1'b1
  } asc_tx_st_t;
  typedef enum logic [1:0] {
    asc_rx_idle = 2'b00,
    asc_rx_start = 2'b01,
    asc_rx_data = 2'b10
  } asc_rx_st_t;
endpackage

// ==== rtl/asc_ctrl.sv ====
`timescale 1ns/10ps
`include "asc_cfg.svh"
// Contract
// - writing tx_holding_reg clears tx_holding_empty; moving it to shift register sets it
// - tx_holding_empty reads one during peripheral_halt_mode; reset empties the holding register
// - clear-to-send pin high holds tx_holding_empty at zero except in peripheral_halt_mode
// - transmit interrupt when tx_irq_enable and tx_holding_empty; reset clears enable
// - multidrop with wake-up filter: only frames with proc bit one touch flags
// - otherwise every frame updates receive-full and error flags; reset clears filter
// - clearing rx_on aborts reception, keeps data and flags; halt and reset clear it
// - clearing tx_on aborts sending, keeps holding data and flag; halt and reset clear it
// - request_send_out pin follows its bit at once; reset sets the bit
// - ext_clk1_pin_off one routes dma_end_strobe to pin, zero gives data clock
// - in multidrop mode bit 3 reads last received proc bit
// - writing zero to control A bit 3 clears overrun, framing and parity flags
// - format bits select data length, parity enable and stop bit count
// - frame order: start, data, optional parity, stop bits
// - multidrop transmitter sends tx_proc_flag_bit as frame proc bit
// - multidrop frame: start, 7/8 data, proc bit, stops, never parity
// - non-multidrop frame follows all three format bits; reset clears multidrop_format
// - transmitter double buffered, idle line driven high
// - overrun set when holding full and another frame completes
// - receive interrupt when enabled and receive-full or any error flag set
module asc_ctrl (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic peripheral_halt_mode_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic [1:0] rxd_i,
  input wire logic [1:0] clear_send_n_i,
  input wire logic dma_end_strobe_i,
  output logic [1:0] txd_o,
  output logic [1:0] tx_irq_o,
  output logic [1:0] rx_irq_o,
  output logic request_send_out_n_o,
  output logic clk1_pin_o,
  output logic clk1_pin_oe_n_o
);
  import asc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off, input int ch);
    hit = (addr == (off + 8'(ch)));
  endfunction
  // frame image, start bit at index 0, data lsb first, then parity or proc bit, then stops
  function automatic logic [15:0] build_frame(input logic [7:0] d, input logic [7:0] a, input logic [7:0] b);
    logic [11:0] v;
    logic [3:0] n;
    logic par;
    v = 12'hFFF;
    v[0] = 1'b0;
    n = 4'h1;
    par = b[`ASC_B_ODD] ^ (^d[6:0]) ^ (a[`ASC_A_LEN8] & d[7]);
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || a[`ASC_A_LEN8]) begin
        v[n] = d[i];
        n = n + 4'h1;
      end
    end
    if (b[`ASC_B_MP]) begin
      v[n] = b[`ASC_B_TXMPB];
      n = n + 4'h1;
    end else if (a[`ASC_A_PAR]) begin
      v[n] = par;
      n = n + 4'h1;
    end
    n = n + 4'h1 + {3'h0, a[`ASC_A_STOP2]};
    build_frame = {n, v};
  endfunction
  localparam logic [`ASC_DIV_W-1:0] BitLast = `ASC_DIV_W'(`ASC_BIT_CYC - 1);
  localparam logic [`ASC_DIV_W-1:0] HalfLast = `ASC_DIV_W'(`ASC_BIT_CYC / 2 - 1);
  logic [7:0] ctla_q [2];
  logic [7:0] rdv [2];
  logic [1:0] rhit;
  logic [1:0] txd_d;
  logic [1:0] tx_irq_d;
  logic [1:0] rx_irq_d;

  // ****************************************
  // per channel transmitter, receiver and registers
  // ****************************************
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    logic [7:0] a_d, b_q, b_d, tdr_q, tdr_d, rdr_q, rdr_d;
    logic full_q, full_d, rx_holding_full_q, rx_holding_full_d, overrun_flag_q, overrun_flag_d, pe_q, pe_d, fe_q, fe_d;
    logic rie_q, rie_d, tie_q, tie_d, mpbr_q, mpbr_d;
    asc_tx_st_t tst_q, tst_d;
    asc_rx_st_t rst_q, rst_d;
    logic [11:0] tsh_q, tsh_d, rbits_q, rbits_d;
    logic [3:0] tcnt_q, tcnt_d, ridx_q, ridx_d;
    logic [`ASC_DIV_W-1:0] tdiv_q, tdiv_d, rdiv_q, rdiv_d;
    logic wr_a, wr_b, wr_s, wr_t, wr_r, rd_r, tx_holding_empty, tx_load, rx_done;
    logic [15:0] fr;
    logic [11:0] bits;
    logic [3:0] dl, total;
    logic ext, stop_ok, accept;
    logic [7:0] rdata;
    always_comb begin
      wr_a = io_wr_i && hit(io_addr_i, `ASC_OFF_CTLA, g);
      wr_b = io_wr_i && hit(io_addr_i, `ASC_OFF_CTLB, g);
      wr_s = io_wr_i && hit(io_addr_i, `ASC_OFF_STAT, g);
      wr_t = io_wr_i && hit(io_addr_i, `ASC_OFF_TDR, g);
      wr_r = io_wr_i && hit(io_addr_i, `ASC_OFF_RDR, g);
      rd_r = io_rd_i && hit(io_addr_i, `ASC_OFF_RDR, g);
      a_d = wr_a ? io_wdata_i : ctla_q[g];
      a_d[`ASC_A_RXON] = a_d[`ASC_A_RXON] && !peripheral_halt_mode_i;
      a_d[`ASC_A_TXON] = a_d[`ASC_A_TXON] && !peripheral_halt_mode_i;
      b_d = wr_b ? io_wdata_i : b_q;
      rie_d = wr_s ? io_wdata_i[`ASC_S_RIE] : rie_q;
      tie_d = wr_s ? io_wdata_i[`ASC_S_TIE] : tie_q;
      tx_holding_empty = peripheral_halt_mode_i || (!full_q && !clear_send_n_i[g]);
      tx_irq_d[g] = tie_q && tx_holding_empty;
      // transmitter
      tdr_d = wr_t ? io_wdata_i : tdr_q;
      full_d = full_q;
      tst_d = tst_q;
      tsh_d = tsh_q;
      tcnt_d = tcnt_q;
      tdiv_d = tdiv_q;
      fr = build_frame(tdr_q, ctla_q[g], b_q);
      tx_load = ctla_q[g][`ASC_A_TXON] && tst_q == asc_tx_idle && full_q
                && !clear_send_n_i[g] && !peripheral_halt_mode_i;
      unique case (tst_q)
        asc_tx_idle: begin
          if (tx_load) begin
            tst_d = asc_tx_shift;
            tsh_d = fr[11:0];
            tcnt_d = fr[15:12];
            tdiv_d = BitLast;
            full_d = 1'b0;
          end
        end
        asc_tx_shift: begin
          if (tdiv_q != '0) begin
            tdiv_d = tdiv_q - 1'b1;
          end else begin
            tdiv_d = BitLast;
            tsh_d = {1'b1, tsh_q[11:1]};
            tcnt_d = tcnt_q - 4'h1;
            if (tcnt_q == 4'h1) begin
              tst_d = asc_tx_idle;
            end
          end
        end
      endcase
      if (!ctla_q[g][`ASC_A_TXON]) begin
        tst_d = asc_tx_idle;
      end
      full_d = (full_d || wr_t) && !peripheral_halt_mode_i;
      txd_d[g] = (tst_d == asc_tx_shift) ? tsh_d[0] : 1'b1;
      // receiver
      rst_d = rst_q;
      rbits_d = rbits_q;
      ridx_d = ridx_q;
      rdiv_d = (rdiv_q != '0) ? rdiv_q - 1'b1 : BitLast;
      dl = ctla_q[g][`ASC_A_LEN8] ? 4'h8 : 4'h7;
      ext = b_q[`ASC_B_MP] || ctla_q[g][`ASC_A_PAR];
      total = dl + {3'h0, ext} + 4'h1 + {3'h0, ctla_q[g][`ASC_A_STOP2]};
      bits = rbits_q;
      bits[ridx_q] = rxd_i[g];
      rx_done = 1'b0;
      unique case (rst_q)
        asc_rx_idle: begin
          if (!rxd_i[g]) begin
            rst_d = asc_rx_start;
            rdiv_d = HalfLast;
          end
        end
        asc_rx_start: begin
          if (rdiv_q == '0) begin
            rst_d = rxd_i[g] ? asc_rx_idle : asc_rx_data;
            ridx_d = 4'h0;
          end
        end
        asc_rx_data: begin
          if (rdiv_q == '0) begin
            rbits_d = bits;
            ridx_d = ridx_q + 4'h1;
            if (ridx_q == total - 4'h1) begin
              rx_done = 1'b1;
              rst_d = asc_rx_idle;
            end
          end
        end
        default: begin
          rst_d = asc_rx_idle;
        end
      endcase
      if (!ctla_q[g][`ASC_A_RXON]) begin
        rst_d = asc_rx_idle;
        rx_done = 1'b0;
      end
      stop_ok = bits[dl + {3'h0, ext}] && (!ctla_q[g][`ASC_A_STOP2] || bits[dl + {3'h0, ext} + 4'h1]);
      accept = !(b_q[`ASC_B_MP] && ctla_q[g][`ASC_A_WAKE]) || bits[dl];
      // receive flags, a hardware set wins over a read or error-flag clear in the same cycle, a halt clear wins over the set
      rdr_d = (wr_r && !rx_holding_full_q) ? io_wdata_i : rdr_q;
      rx_holding_full_d = rd_r ? 1'b0 : rx_holding_full_q;
      overrun_flag_d = overrun_flag_q;
      pe_d = pe_q;
      fe_d = fe_q;
      mpbr_d = mpbr_q;
      if (wr_a && !io_wdata_i[`ASC_A_EFR]) begin
        {overrun_flag_d, pe_d, fe_d} = 3'h0;
      end
      if (rx_done && accept) begin
        mpbr_d = b_q[`ASC_B_MP] ? bits[dl] : mpbr_q;
        // a byte landing while the holding register is being read is kept, not an overrun
        if (rx_holding_full_q && !rd_r) begin
          overrun_flag_d = 1'b1;
        end else begin
          rdr_d = ctla_q[g][`ASC_A_LEN8] ? bits[7:0] : {1'b0, bits[6:0]};
          rx_holding_full_d = 1'b1;
          fe_d = fe_d || !stop_ok;
          pe_d = pe_d || (!b_q[`ASC_B_MP] && ctla_q[g][`ASC_A_PAR] &&
                 (bits[dl] != (b_q[`ASC_B_ODD] ^ (^bits[6:0]) ^ (ctla_q[g][`ASC_A_LEN8] & bits[7]))));
        end
      end
      if (peripheral_halt_mode_i) begin
        {rx_holding_full_d, overrun_flag_d, pe_d, fe_d} = 4'h0;
      end
      rx_irq_d[g] = rie_d && (rx_holding_full_d || overrun_flag_d || pe_d || fe_d);
      // read view
      rhit[g] = 1'b1;
      rdata = 8'h00;
      if (hit(io_addr_i, `ASC_OFF_CTLA, g)) begin
        rdata = ctla_q[g];
        rdata[`ASC_A_EFR] = mpbr_q;
      end else if (hit(io_addr_i, `ASC_OFF_CTLB, g)) begin
        rdata = b_q;
        rdata[`ASC_B_PS] = clear_send_n_i[g];
      end else if (hit(io_addr_i, `ASC_OFF_STAT, g)) begin
        rdata = {rx_holding_full_q, overrun_flag_q, pe_q, fe_q, rie_q, 1'b0, tx_holding_empty, tie_q};
      end else if (hit(io_addr_i, `ASC_OFF_TDR, g)) begin
        rdata = tdr_q;
      end else if (hit(io_addr_i, `ASC_OFF_RDR, g)) begin
        rdata = rdr_q;
      end else begin
        rhit[g] = 1'b0;
      end
      rdv[g] = rdata;
    end
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        ctla_q[g] <= (g == 0) ? `ASC_CTLA0_RST : `ASC_CTLA1_RST;
        b_q <= `ASC_CTLB_RST;
        tie_q <= 1'b0;
        rie_q <= 1'b0;
        full_q <= 1'b0;
        rx_holding_full_q <= 1'b0;
        overrun_flag_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        mpbr_q <= 1'b0;
        tdr_q <= 8'h00;
        rdr_q <= 8'h00;
        tst_q <= asc_tx_idle;
        rst_q <= asc_rx_idle;
        tsh_q <= 12'hFFF;
        tcnt_q <= 4'h0;
        tdiv_q <= '0;
        rbits_q <= 12'h000;
        ridx_q <= 4'h0;
        rdiv_q <= '0;
      end else begin
        ctla_q[g] <= a_d;
        b_q <= b_d;
        tie_q <= tie_d;
        rie_q <= rie_d;
        full_q <= full_d;
        rx_holding_full_q <= rx_holding_full_d;
        overrun_flag_q <= overrun_flag_d;
        pe_q <= pe_d;
        fe_q <= fe_d;
        mpbr_q <= mpbr_d;
        tdr_q <= tdr_d;
        rdr_q <= rdr_d;
        tst_q <= tst_d;
        rst_q <= rst_d;
        tsh_q <= tsh_d;
        tcnt_q <= tcnt_d;
        tdiv_q <= tdiv_d;
        rbits_q <= rbits_d;
        ridx_q <= ridx_d;
        rdiv_q <= rdiv_d;
      end
    end
  end

  // ****************************************
  // shared pins and read data
  // ****************************************
  // the channel 1 data clock runs at half the fixed bit rate since the rate selector is not built
  logic [`ASC_DIV_W-1:0] ck_div_q, ck_div_d;
  logic ck_q, ck_d, pin_d;
  logic [7:0] rdata_d;
  logic rts_n_d;

  always_comb begin
    ck_div_d = (ck_div_q != '0) ? ck_div_q - 1'b1 : BitLast;
    ck_d = (ck_div_q == '0) ? !ck_q : ck_q;
    pin_d = gen_ch[1].a_d[`ASC_A_PIN] ? dma_end_strobe_i : ck_d;
    rts_n_d = gen_ch[0].a_d[`ASC_A_PIN];
    rdata_d = io_rdata_o;
    if (io_rd_i) begin
      rdata_d = rhit[0] ? rdv[0] : (rhit[1] ? rdv[1] : 8'h00);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ck_div_q <= '0;
      ck_q <= 1'b0;
      clk1_pin_o <= 1'b0;
      clk1_pin_oe_n_o <= 1'b0;
      request_send_out_n_o <= 1'b1;
      io_rdata_o <= 8'h00;
      txd_o <= 2'b11;
      tx_irq_o <= 2'b00;
      rx_irq_o <= 2'b00;
    end else begin
      ck_div_q <= ck_div_d;
      ck_q <= ck_d;
      clk1_pin_o <= pin_d;
      clk1_pin_oe_n_o <= 1'b0;
      request_send_out_n_o <= rts_n_d;
      io_rdata_o <= rdata_d;
      txd_o <= txd_d;
      tx_irq_o <= tx_irq_d;
      rx_irq_o <= rx_irq_d;
    end
  end
endmodule

// ==== test/asc_ctrl_monitor.sv ====
`timescale 1ns/10ps
// ****
// port checks, channel 0 and shared pin
// ****
module asc_ctrl_mon (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic peripheral_halt_mode_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [1:0] clear_send_n_i,
  input wire logic dma_end_strobe_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic [1:0] txd_o,
  input wire logic [1:0] tx_irq_o,
  input wire logic [1:0] rx_irq_o,
  input wire logic request_send_out_n_o,
  input wire logic clk1_pin_o,
  input wire logic clk1_pin_oe_n_o
);
  logic pin_off_q, pin_off_d;
  // shadow of the pin routing bit, so routing is judged without peeking inside
  always_comb begin
    pin_off_d = pin_off_q;
    if (io_wr_i && io_addr_i == 8'h01) begin
      pin_off_d = io_wdata_i[4];
    end
  end
  always_ff @(posedge clock_i) begin
    pin_off_q <= srst_i ? 1'h0 : pin_off_d;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_RESET_IDLE: assert property ($fell(srst_i) |-> txd_o == 2'h3 && request_send_out_n_o && io_rdata_o == 8'h00
    && tx_irq_o == 2'h0 && rx_irq_o == 2'h0) else $error("outputs not at rest after reset");
  AST_RTS_FOLLOW: assert property (io_wr_i && io_addr_i == 8'h00 |=> request_send_out_n_o == $past(io_wdata_i[4]))
    else $error("request pin does not follow its bit");
  AST_CLK1_ROUTE: assert property (pin_off_q |=> clk1_pin_o == $past(dma_end_strobe_i))
    else $error("shared pin does not carry dma end");
  AST_PIN_DRIVE: assert property (pin_off_q |-> !clk1_pin_oe_n_o)
    else $error("shared pin not driven");
  AST_TDR_WRITE: assert property (io_wr_i && io_addr_i == 8'h06 && !peripheral_halt_mode_i ##1 !peripheral_halt_mode_i
    |=> !tx_irq_o[0]) else $error("holding write left empty flag set");
  AST_CTS_BLOCK: assert property ((clear_send_n_i[0] && !peripheral_halt_mode_i) [*3] |=> !tx_irq_o[0])
    else $error("empty flag seen while clear-to-send high");
  AST_HALT_RX: assert property (peripheral_halt_mode_i [*3] |=> rx_irq_o == 2'h0)
    else $error("receive request during halt");
  AST_HALT_IDLE: assert property (peripheral_halt_mode_i [*3] |=> txd_o == 2'h3)
    else $error("line not idle during halt");
endmodule
bind asc_ctrl asc_ctrl_mon asc_ctrl_mon_i (.clock_i, .srst_i, .peripheral_halt_mode_i, .io_addr_i, .io_wr_i,
  .io_wdata_i, .clear_send_n_i, .dma_end_strobe_i, .io_rdata_o, .txd_o, .tx_irq_o, .rx_irq_o,
  .request_send_out_n_o, .clk1_pin_o, .clk1_pin_oe_n_o);

// ==== test/asc_far_end.sv ====
`timescale 1ns/10ps
// ****
// remote serial node on channel 0
// ****
module asc_far_end #(
  parameter int BIT_CYC = 1085
) (
  input wire logic clock_i,
  input wire logic txd_i,
  output logic rxd_o
);
  initial rxd_o = 1'h1; // idle line high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin // start first, then data lsb first
      rxd_o = bits[i];
      repeat (BIT_CYC) @(negedge clock_i);
    end
    rxd_o = 1'h1;
  endtask
  // samples mid bit; after 100 cycles with no start it samples the line anyway, so a late start shows up as a mismatch
  task automatic capture(input int n, output logic [11:0] bits);
    int w;
    bits = 12'hFFF;
    w = 0;
    while (txd_i !== 1'h0 && w < 100) begin
      @(negedge clock_i);
      w++;
    end
    repeat (BIT_CYC / 2) @(negedge clock_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (BIT_CYC) @(negedge clock_i);
    end
  endtask
endmodule

// ==== test/asc_ctrl_tb_top.sv ====
`timescale 1ns/10ps
// ****
// channel 0 bench
// ****
module asc_ctrl_tb_top;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0A};
  localparam logic [7:0] RV [6] = '{8'h10, 8'h00, 8'h07, 8'h07, 8'h02, 8'h00};
  localparam logic [7:0] EX [4] = '{8'h8A, 8'hAA, 8'hAA, 8'hEA};
  localparam logic [2:0] FM [4] = '{3'h7, 3'h2, 3'h4, 3'h3};
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic halt = 1'h0, wr = 1'h0, rd = 1'h0, dma = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [1:0] cts_n = 2'h0, txd, tx_irq, rx_irq;
  logic rxd0, rts_n, pin, pin_oe_n;
  int num_errors = 0, n_compared = 0;
  always #4 clock_i = ~clock_i;
  always @(negedge clock_i) dma <= 1'($urandom);
  asc_ctrl asc_ctrl_i (.clock_i, .srst_i, .peripheral_halt_mode_i(halt), .io_addr_i(addr), .io_wr_i(wr),
    .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata), .rxd_i({1'h1, rxd0}), .clear_send_n_i(cts_n),
    .dma_end_strobe_i(dma), .txd_o(txd), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
    .request_send_out_n_o(rts_n), .clk1_pin_o(pin), .clk1_pin_oe_n_o(pin_oe_n));
  asc_far_end asc_far_end_i (.clock_i, .txd_i(txd[0]), .rxd_o(rxd0));
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [2:0] f, input logic mp, pb, odd,
                                         output int n);
    logic [11:0] b;
    int k;
    b = 12'hFFF;
    b[0] = 1'h0;
    k = f[2] ? 8 : 7;
    for (int i = 0; i < k; i++) b[1 + i] = d[i];
    n = 1 + k;
    if (mp || f[1]) begin
      b[n] = mp ? pb : (^(d & (f[2] ? 8'hFF : 8'h7F))) ^ odd;
      n++;
    end
    n += f[0] ? 2 : 1;
    return b;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr = a;
    wdata = d;
    wr = 1'h1;
    @(negedge clock_i);
    wr = 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr = a;
    rd = 1'h1;
    @(negedge clock_i);
    rd = 1'h0;
    d = rdata;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic cmp_frame(input logic [11:0] got, input logic [11:0] exp, input string w);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // four frames of at most 12 bits plus register traffic fit well inside this
  initial begin
    #(8 * 70000);
    num_errors++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v, drx, d1;
    logic [11:0] exp, got, rb;
    int n;
    void'($urandom(32'h00d81e0e));
    repeat (5) @(negedge clock_i);
    srst_i = 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(RA[i], v);
      cmp_reg(v, RV[i], "reset value");
    end
    $display("test reset values done");
    wr_reg(8'h04, 8'h01);
    cts_n = 2'h1;
    repeat (4) @(negedge clock_i);
    cmp_reg({7'h0, tx_irq[0]}, 8'h00, "irq with cts high");
    cts_n = 2'h0;
    repeat (3) @(negedge clock_i);
    cmp_reg({6'h0, tx_irq}, 8'h01, "irq when empty");
    wr_reg(8'h06, 8'h5A);
    repeat (2) @(negedge clock_i);
    cmp_reg({7'h0, tx_irq[0]}, 8'h00, "irq after holding write");
    halt = 1'h1;
    repeat (4) @(negedge clock_i);
    cmp_reg({7'h0, tx_irq[0]}, 8'h01, "irq in halt");
    halt = 1'h0;
    wr_reg(8'h00, 8'h00);
    cmp_reg({7'h0, rts_n}, 8'h00, "request pin low");
    wr_reg(8'h04, 8'h08);
    wr_reg(8'h01, 8'h10);
    $display("test transmit flag done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h00, {i > 1, 4'hF, FM[i]});
      wr_reg(8'h02, {i == 2, i > 1, 1'h0, i == 0, 4'h7});
      v = 8'($urandom);
      drx = 8'($urandom);
      exp = frame(v, FM[i], i > 1, i == 2, i == 0, n);
      rb = frame(drx, FM[i], i > 1, i == 3, i == 0, n);
      // one parity error, so the error flag stays up for the overrun frame
      if (i == 1) rb[n - 2] = ~rb[n - 2];
      if (i == 1) d1 = drx;
      wr_reg(8'h06, v);
      fork
        asc_far_end_i.capture(n, got);
        asc_far_end_i.send(rb, n);
      join
      repeat (8) @(negedge clock_i);
      cmp_frame(got, exp, "tx frame");
      rd_reg(8'h04, v);
      cmp_reg(v, EX[i], "status after frame");
      cmp_reg({7'h0, rx_irq[0]}, 8'h01, "rx irq");
      if (i == 0) begin
        rd_reg(8'h08, v);
        cmp_reg(v, drx, "rx data");
      end
      $display("test frame %0d done", i);
    end
    wr_reg(8'h00, 8'hF3);
    rd_reg(8'h04, v);
    cmp_reg(v, 8'h8A, "flags after error clear");
    rd_reg(8'h08, v);
    cmp_reg(v, {1'h0, d1[6:0]}, "held rx data");
    repeat (2) @(negedge clock_i);
    cmp_reg({7'h0, rx_irq[0]}, 8'h00, "rx irq released");
    $display("test error clear done");
    report_and_stop();
  end
endmodule
